/* File: sdr_ctrl.sv */
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "sdr_map.svh"

// Behaviour
// (R01) Bank hold 1: plain commands, row open
// (R02) Bank hold 0: auto-precharge read and write
// (R03) Software: bank active only with half area
// (R04) Software: both areas SDRAM needs auto-precharge
// (R05) Reserved control bits read zero
// (R06) Row code selects 11, 12, 13 bits
// (R07) Column code selects 8, 9, 10 bits
// (R08) Timer registers need full keyed write
// (R09) Timer register upper half reads zero
// (R10) Counter equals match value sets flag
// (R11) Flag clears by zero after read-as-one
// (R12) Interrupt enable gates compare request
// (R13) Match with refresh on holds request
// (R14) Interrupt output is flag and enable
module sdr_ctrl #(
    parameter int ADDR_W = 12,
    parameter int TICK_DIV = `SDR_TICK_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic refresh_done,
    output logic refresh_req,
    output logic cmp_irq,
    output logic auto_precharge,
    output logic [3:0] row_bits,
    output logic [3:0] col_bits,
    output logic geom_error
);
    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    initial begin
        if (ADDR_W < 9 || ADDR_W > 32) begin
            $error("sdr_ctrl: ADDR_W must be 9 to 32");
        end
    end

    // ****************************************************************
    // Sub-blocks
    // ****************************************************************
    sdr_core_if core ();

    sdr_geom u_geom (
        .core(core)
    );

    sdr_timer #(
        .TICK_DIV(TICK_DIV)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .core(core)
    );

    // ****************************************************************
    // Register state
    // ****************************************************************
    sdr_pkg::sdr_apb_state_t state;
    logic bank_hold;
    logic refresh_on;
    logic [1:0] row_code;
    logic [1:0] col_code;
    logic cmp_flag;
    logic irq_en;
    logic clear_armed;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic [7:0] offset;
    logic in_range;
    logic setup;
    logic done;
    logic do_write;
    logic do_read;
    logic keyed;
    logic hit_ctrl;
    logic hit_csr;
    logic hit_cnt;
    logic hit_match;
    logic mapped;

    assign offset = paddr[7:0];
    assign in_range = (paddr[ADDR_W-1:8] == '0);
    assign setup = psel && !penable;
    // The access edge: pready is high exactly while in the answer state
    assign done = (state == sdr_pkg::sdr_answer) && psel && penable;
    assign do_write = done && pwrite;
    assign do_read = done && !pwrite;
    // Timer registers take only a full-word write carrying the key
    assign keyed = (pstrb == `SDR_FULL_STRB)
        && (pwdata[`SDR_KEY_HI:`SDR_KEY_LO] == `SDR_KEY); // [R08]
    assign hit_ctrl = in_range && offset == `SDR_OFF_CTRL;
    assign hit_csr = in_range && offset == `SDR_OFF_CSR;
    assign hit_cnt = in_range && offset == `SDR_OFF_CNT;
    assign hit_match = in_range && offset == `SDR_OFF_MATCH;
    assign mapped = hit_ctrl || hit_csr || hit_cnt || hit_match;

    // Counter and match value writes go to the timer block
    assign core.cnt_we = do_write && hit_cnt && keyed; // [R08]
    assign core.match_we = do_write && hit_match && keyed; // [R08]
    assign core.wdata = pwdata[7:0];
    assign core.row_code = row_code;
    assign core.col_code = col_code;
    assign core.bank_hold = bank_hold;

    // ****************************************************************
    // APB answer sequencer
    // ****************************************************************
    // No wait state: pready is set at the setup edge, so prdata and pready come straight from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= sdr_pkg::sdr_idle;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            case (state)
                sdr_pkg::sdr_idle: begin
                    if (setup) begin
                        state <= sdr_pkg::sdr_answer;
                        pready <= 1'b1;
                        pslverr <= !mapped;
                    end
                end
                sdr_pkg::sdr_answer: begin
                    if (psel && penable) begin
                        state <= sdr_pkg::sdr_idle;
                        pready <= 1'b0;
                        pslverr <= 1'b0;
                    end
                end
                default: begin
                    state <= sdr_pkg::sdr_idle;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [31:0] next_rdata;

    // Reserved bits and the key half always come back as zero
    always_comb begin
        next_rdata = `SDR_RST_WORD;
        if (hit_ctrl) begin
            next_rdata[`SDR_CTRL_REFRESH_ON] = refresh_on;
            next_rdata[`SDR_CTRL_BANK_HOLD] = bank_hold;
            next_rdata[`SDR_CTRL_ROW_HI:`SDR_CTRL_ROW_LO] = row_code;
            next_rdata[`SDR_CTRL_COL_HI:`SDR_CTRL_COL_LO] = col_code; // [R05]
        end else if (hit_csr) begin
            next_rdata[`SDR_CSR_FLAG] = cmp_flag;
            next_rdata[`SDR_CSR_IRQ_EN] = irq_en; // [R09]
        end else if (hit_cnt) begin
            next_rdata[7:0] = core.cnt;
        end else if (hit_match) begin
            next_rdata[7:0] = core.match_val;
        end
    end

    // Captured at the setup edge, held through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `SDR_RST_WORD;
        end else if (setup && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    // ****************************************************************
    // SDRAM control register
    // ****************************************************************
    // Byte lanes 0 and 1; reserved bits are simply not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_code <= 2'h0;
            col_code <= 2'h0;
            bank_hold <= 1'b0;
            refresh_on <= 1'b0;
        end else if (do_write && hit_ctrl) begin
            if (pstrb[0]) begin
                row_code <= pwdata[`SDR_CTRL_ROW_HI:`SDR_CTRL_ROW_LO]; // [R06]
                col_code <= pwdata[`SDR_CTRL_COL_HI:`SDR_CTRL_COL_LO]; // [R07]
            end
            if (pstrb[1]) begin
                bank_hold <= pwdata[`SDR_CTRL_BANK_HOLD]; // [R01] [R02]
                refresh_on <= pwdata[`SDR_CTRL_REFRESH_ON];
            end
        end
    end

    // ****************************************************************
    // Refresh timer control/status
    // ****************************************************************
    logic csr_write;
    assign csr_write = do_write && hit_csr && keyed; // [R08]

    // Interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en <= 1'b0;
        end else if (csr_write) begin
            irq_en <= pwdata[`SDR_CSR_IRQ_EN];
        end
    end

    // A read that sees the flag set arms the clear; a keyed write consumes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_armed <= 1'b0;
        end else if (do_read && hit_csr && prdata[`SDR_CSR_FLAG]) begin
            clear_armed <= 1'b1; // Only a read that returned one arms [R11]
        end else if (csr_write) begin
            clear_armed <= 1'b0;
        end
    end

    // Hardware set wins over the software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_flag <= 1'b0;
        end else if (core.match_pulse) begin
            cmp_flag <= 1'b1; // [R10]
        end else if (csr_write && clear_armed && !pwdata[`SDR_CSR_FLAG]) begin
            cmp_flag <= 1'b0; // [R11]
        end
    end

    // ****************************************************************
    // Refresh request and interrupt
    // ****************************************************************
    // A match over an unserved request merges into it; no count is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refresh_req <= 1'b0;
        end else if (core.match_pulse && refresh_on) begin
            refresh_req <= 1'b1; // [R13]
        end else if (refresh_done) begin
            refresh_req <= 1'b0;
        end
    end

    // Registered so the pin stays glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_irq <= 1'b0;
        end else begin
            cmp_irq <= cmp_flag && irq_en; // [R12] [R14]
        end
    end

    // ****************************************************************
    // Geometry outputs
    // ****************************************************************
    // Software must keep area usage consistent with the mode [R03] [R04]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_precharge <= 1'b1;
            row_bits <= `SDR_ROW_BASE;
            col_bits <= `SDR_COL_BASE;
            geom_error <= 1'b0;
        end else begin
            auto_precharge <= (core.mode == sdr_pkg::sdr_auto_precharge); // [R01] [R02]
            row_bits <= core.row_bits; // [R06]
            col_bits <= core.col_bits; // [R07]
            geom_error <= core.geom_bad;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    mode_follows_a: assert property ( // [R01]
        @(posedge pclk) disable iff (!presetn)
        bank_hold |-> ##1 !auto_precharge)
        else $error("bank hold did not select bank active");

    precharge_mode_a: assert property ( // [R02]
        @(posedge pclk) disable iff (!presetn)
        !bank_hold |-> ##1 auto_precharge)
        else $error("auto-precharge mode not selected");

    reserved_zero_a: assert property ( // [R05]
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_ctrl) |=> (prdata[7:5] == 3'h0 && prdata[2] == 1'b0))
        else $error("reserved control bits read nonzero");

    row_width_a: assert property ( // [R06]
        @(posedge pclk) disable iff (!presetn)
        (row_code != `SDR_CODE_BAD) |-> ##1 (row_bits == 4'(`SDR_ROW_BASE + $past(row_code))))
        else $error("row width decode wrong");

    col_width_a: assert property ( // [R07]
        @(posedge pclk) disable iff (!presetn)
        (col_code != `SDR_CODE_BAD) |-> ##1 (col_bits == 4'(`SDR_COL_BASE + $past(col_code))))
        else $error("column width decode wrong");

    key_reject_a: assert property ( // [R08]
        @(posedge pclk) disable iff (!presetn)
        (do_write && hit_csr && !keyed && !core.match_pulse) |=> $stable(irq_en) && $stable(cmp_flag))
        else $error("unkeyed write changed timer status");

    upper_zero_a: assert property ( // [R09]
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_csr) |=> (prdata[31:16] == 16'h0000))
        else $error("upper half of status read nonzero");

    match_sets_a: assert property ( // [R10]
        @(posedge pclk) disable iff (!presetn)
        core.match_pulse |=> cmp_flag ##1 cmp_irq == $past(irq_en))
        else $error("match did not set flag");

    blind_clear_a: assert property ( // [R11]
        @(posedge pclk) disable iff (!presetn)
        (cmp_flag && !clear_armed && csr_write) |=> cmp_flag)
        else $error("flag cleared without prior read");

    irq_gate_a: assert property ( // [R14]
        @(posedge pclk) disable iff (!presetn)
        (cmp_flag && irq_en) [*2] |-> cmp_irq)
        else $error("interrupt not raised");

    irq_block_a: assert property ( // [R12]
        @(posedge pclk) disable iff (!presetn)
        !irq_en |=> !cmp_irq)
        else $error("interrupt passed while disabled");

    refresh_hold_a: assert property ( // [R13]
        @(posedge pclk) disable iff (!presetn)
        (core.match_pulse && refresh_on) |=> refresh_req ##1 (refresh_req || $past(refresh_done)))
        else $error("refresh request lost");
endmodule : sdr_ctrl

/* File: sdr_map.svh */
`ifndef SDR_MAP_SVH
`define SDR_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses on the APB)
// ****************************************************************
`define SDR_OFF_CTRL 8'h00
`define SDR_OFF_CSR 8'h04
`define SDR_OFF_CNT 8'h08
`define SDR_OFF_MATCH 8'h0c

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define SDR_CTRL_REFRESH_ON 11
`define SDR_CTRL_BANK_HOLD 8
`define SDR_CTRL_ROW_HI 4
`define SDR_CTRL_ROW_LO 3
`define SDR_CTRL_COL_HI 1
`define SDR_CTRL_COL_LO 0
`define SDR_CSR_FLAG 7
`define SDR_CSR_IRQ_EN 6
`define SDR_KEY_HI 31
`define SDR_KEY_LO 16
`define SDR_KEY 16'ha55a
`define SDR_FULL_STRB 4'hf
`define SDR_ROW_BASE 4'hb
`define SDR_COL_BASE 4'h8
`define SDR_CODE_BAD 2'h3

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define SDR_RST_WORD 32'h0000_0000
`define SDR_RST_BYTE 8'h00
`define SDR_TICK_DIV 4

`endif

/* File: sdr_pkg.sv */
package sdr_pkg;

    // APB answer sequencer
    typedef enum logic [0:0] {
        sdr_idle = 1'b0,
        sdr_answer = 1'b1
    } sdr_apb_state_t;

    // Column command flavour, driven on the auto-precharge address bit
    typedef enum logic [0:0] {
        sdr_bank_active = 1'b0,
        sdr_auto_precharge = 1'b1
    } sdr_access_mode_t;

endpackage : sdr_pkg

/* File: sdr_core_if.sv */
`timescale 1ns/1ps

// Signals between the register core, the geometry decoder and the timer
interface sdr_core_if;
    logic [1:0] row_code;
    logic [1:0] col_code;
    logic bank_hold;
    logic [3:0] row_bits;
    logic [3:0] col_bits;
    sdr_pkg::sdr_access_mode_t mode;
    logic geom_bad;
    logic cnt_we;
    logic match_we;
    logic [7:0] wdata;
    logic [7:0] cnt;
    logic [7:0] match_val;
    logic match_pulse;

    modport geom (input row_code, input col_code, input bank_hold,
                  output row_bits, output col_bits, output mode, output geom_bad);
    modport timer (input cnt_we, input match_we, input wdata,
                   output cnt, output match_val, output match_pulse);
    modport ctrl (output row_code, output col_code, output bank_hold,
                  input row_bits, input col_bits, input mode, input geom_bad,
                  output cnt_we, output match_we, output wdata,
                  input cnt, input match_val, input match_pulse);
endinterface : sdr_core_if

/* File: sdr_geom.sv */
`timescale 1ns/1ps
`include "sdr_map.svh"

// ****************************************************************
// Area 3 address geometry and access mode decode
// ****************************************************************
module sdr_geom (
    sdr_core_if.geom core
);
    // Width is a base plus the code; the forbidden code maps to zero
    function automatic logic [3:0] sdr_width_of(input logic [1:0] code, input logic [3:0] base);
        sdr_width_of = (code == `SDR_CODE_BAD) ? 4'h0 : 4'(base + {2'b00, code});
    endfunction : sdr_width_of

    // Row 11/12/13, column 8/9/10 bits
    always_comb begin
        core.row_bits = sdr_width_of(core.row_code, `SDR_ROW_BASE); // [R06]
        core.col_bits = sdr_width_of(core.col_code, `SDR_COL_BASE); // [R07]
        core.geom_bad = (core.row_code == `SDR_CODE_BAD) || (core.col_code == `SDR_CODE_BAD);
    end

    // Bank hold keeps rows open, otherwise every access precharges
    always_comb begin
        if (core.bank_hold) begin
            core.mode = sdr_pkg::sdr_bank_active; // [R01]
        end else begin
            core.mode = sdr_pkg::sdr_auto_precharge; // [R02]
        end
    end
endmodule : sdr_geom

/* File: sdr_timer.sv */
`timescale 1ns/1ps
`include "sdr_map.svh"

// ****************************************************************
// Refresh timer counter and match value
// ****************************************************************
module sdr_timer #(
    parameter int TICK_DIV = `SDR_TICK_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    sdr_core_if.timer core
);
    initial begin
        if (TICK_DIV < 1 || TICK_DIV > 65535) begin
            $error("sdr_timer: TICK_DIV out of range");
        end
    end

    logic [15:0] div;
    logic tick;

    // Prescaler: one-cycle count enable every TICK_DIV clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 16'h0000;
            tick <= 1'b0;
        end else if (div == 16'(TICK_DIV - 1)) begin
            div <= 16'h0000;
            tick <= 1'b1;
        end else begin
            div <= div + 16'h0001;
            tick <= 1'b0;
        end
    end

    // Match value register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core.match_val <= `SDR_RST_BYTE;
        end else if (core.match_we) begin
            core.match_val <= core.wdata;
        end
    end

    // Counter clears on a match and wraps after 255; a write wins over counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core.cnt <= `SDR_RST_BYTE;
            core.match_pulse <= 1'b0;
        end else if (core.cnt_we) begin
            core.cnt <= core.wdata;
            core.match_pulse <= 1'b0;
        end else if (tick && core.cnt == core.match_val) begin
            core.cnt <= `SDR_RST_BYTE;
            core.match_pulse <= 1'b1;
        end else begin
            core.cnt <= tick ? core.cnt + 8'h01 : core.cnt;
            core.match_pulse <= 1'b0;
        end
    end
endmodule : sdr_timer

/* File: sdr_ref_model.sv */
`timescale 1ns/1ps

// ****************************************************************
// Memory side: performs a refresh some cycles after each request
// ****************************************************************
module sdr_ref_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic refresh_req,
    input wire logic [3:0] lag,
    output logic refresh_done
);
    logic [3:0] wait_cnt;

    // Lag 0 answers at once, larger lags model a busy memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 4'h0;
            refresh_done <= 1'b0;
        end else if (refresh_done) begin
            refresh_done <= 1'b0; // One-cycle completion pulse
            wait_cnt <= 4'h0;
        end else if (refresh_req === 1'b1) begin
            if (wait_cnt >= lag) begin
                refresh_done <= 1'b1; // Refresh performed
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end else begin
            wait_cnt <= 4'h0;
        end
    end
endmodule : sdr_ref_model

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "sdr_map.svh"
`define CHK(got, exp) check_val(32'(got), 32'(exp))

module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bank;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic [3:0] pstrb, row_bits, col_bits, lag;
    logic refresh_done, refresh_req, cmp_irq, auto_precharge, geom_error, resp_err;
    int mismatches, num_checks, n;

    // ****************************************************************
    // Clock, design and memory side
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Unit divider keeps the match period short
    sdr_ctrl #(.TICK_DIV(1)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .refresh_done(refresh_done), .refresh_req(refresh_req), .cmp_irq(cmp_irq),
        .auto_precharge(auto_precharge), .row_bits(row_bits), .col_bits(col_bits),
        .geom_error(geom_error));

    sdr_ref_model mem_u (.pclk(pclk), .presetn(presetn), .refresh_req(refresh_req),
        .lag(lag), .refresh_done(refresh_done));

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    task automatic timed_out;
        mismatches++;
        $display("wait limit reached at %0t", $time);
        summarize();
    endtask : timed_out

    // Request is held until pready is sampled high; the bound cuts a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) timed_out();
        rd_data = prdata;
        resp_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, `SDR_FULL_STRB);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
    endtask : rd

    task automatic keyed(input logic [11:0] a, input logic [7:0] v);
        wr(a, {`SDR_KEY, 8'h00, v});
    endtask : keyed

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        lag = 4'h8;
        mismatches = 0;
        num_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(auto_precharge, 1'b1);
        `CHK({row_bits, col_bits}, 8'hb8);
        `CHK({geom_error, refresh_req, cmp_irq}, 3'h0);
        rd(`SDR_OFF_CTRL);
        `CHK(rd_data, 32'h0000_0000);
        `CHK(resp_err, 1'b0);
        $display("test reset done");

        // Every legal code pair; reserved bits written as one must read zero
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c < 3; c++) begin
                bank = 1'(r + c); // Bank hold only with half area 3 in use
                wr(`SDR_OFF_CTRL, {23'h0, bank, 3'h7, 2'(r), 1'b1, 2'(c)});
                rd(`SDR_OFF_CTRL);
                `CHK(rd_data, {23'h0, bank, 3'h0, 2'(r), 1'b0, 2'(c)});
                `CHK(row_bits, 11 + r);
                `CHK(col_bits, 8 + c);
                `CHK(auto_precharge, !bank);
            end
        end
        wr(`SDR_OFF_CTRL, 32'h0000_001b);
        rd(`SDR_OFF_CTRL);
        `CHK({geom_error, row_bits, col_bits}, 9'h100);
        wr(`SDR_OFF_CTRL, 32'h0000_0800); // Both areas SDRAM: auto-precharge
        $display("test geometry done");

        // Timer set up, then any stale flag cleared by read and zero write
        keyed(`SDR_OFF_MATCH, 8'h40);
        keyed(`SDR_OFF_CNT, 8'h00);
        rd(`SDR_OFF_CSR);
        keyed(`SDR_OFF_CSR, 8'h00);
        rd(`SDR_OFF_CSR);
        `CHK(rd_data, 32'h0000_0000);
        keyed(12'h104, 8'h40); // Aliases status but lies outside the map
        `CHK(resp_err, 1'b1);
        wr(`SDR_OFF_CSR, 32'h5aa5_0040);
        rd(`SDR_OFF_CSR);
        `CHK(rd_data, 32'h0000_0000);
        apb(1'b1, `SDR_OFF_CSR, {`SDR_KEY, 16'h0040}, 4'h3);
        rd(`SDR_OFF_CSR);
        `CHK(rd_data, 32'h0000_0000);
        rd(`SDR_OFF_MATCH);
        `CHK(rd_data, 32'h0000_0040);
        keyed(`SDR_OFF_CSR, 8'h40);
        rd(`SDR_OFF_CSR);
        `CHK(rd_data, 32'h0000_0040);
        $display("test keyed access done");

        // Match with enable and refresh on; clear needs a read first
        n = 0;
        while (cmp_irq !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (cmp_irq !== 1'b1) timed_out();
        `CHK(refresh_req, 1'b1);
        keyed(`SDR_OFF_CSR, 8'h40);
        rd(`SDR_OFF_CSR);
        `CHK(rd_data, 32'h0000_00c0);
        keyed(`SDR_OFF_CSR, 8'h40);
        rd(`SDR_OFF_CSR);
        `CHK(rd_data, 32'h0000_0040);
        `CHK(cmp_irq, 1'b0);
        `CHK(refresh_req, 1'b0);
        $display("test match and clear done");

        // Enable off: next match sets the flag but no interrupt
        lag <= 4'h0;
        keyed(`SDR_OFF_CSR, 8'h00);
        n = 0;
        rd_data = 32'h0000_0000;
        while (rd_data[7] !== 1'b1 && n < 60) begin
            rd(`SDR_OFF_CSR);
            n++;
        end
        if (rd_data[7] !== 1'b1) timed_out();
        `CHK(rd_data, 32'h0000_0080);
        `CHK(cmp_irq, 1'b0);
        $display("test masked match done");
        summarize();
    end
endmodule : tb_top
